// *** hw/ets_pkg.sv ***
// Package for the energy-saving and time-sync management register set.
// Assumes a clause 22 register port that carries accesses to registers 13 and 14.
package ets_pkg;

  // Basic register numbers that open the extended space
  localparam logic [4:0] ETS_REG_MMD_CTRL = 5'h0D;
  localparam logic [4:0] ETS_REG_MMD_DATA = 5'h0E;

  // Access-control register fields
  localparam int ETS_CTRL_FUNC_HI = 15;
  localparam int ETS_CTRL_FUNC_LO = 14;
  localparam int ETS_CTRL_DEV_HI = 4;
  localparam logic [1:0] ETS_FUNC_ADDR = 2'h0;
  localparam logic [1:0] ETS_FUNC_DATA = 2'h1;
  localparam logic [1:0] ETS_FUNC_DATA_INC_RW = 2'h2;
  localparam logic [1:0] ETS_FUNC_DATA_INC_WR = 2'h3;

  // Device numbers
  localparam logic [4:0] ETS_DEV_PMA = 5'h01;
  localparam logic [4:0] ETS_DEV_PCS = 5'h03;
  localparam logic [4:0] ETS_DEV_XS = 5'h04;
  localparam logic [4:0] ETS_DEV_AN = 5'h07;

  // Register numbers inside the devices (decimal 1, 20, 22, 60, 61, 1800..1807)
  localparam logic [15:0] ETS_ADR_STATUS1 = 16'h0001;
  localparam logic [15:0] ETS_ADR_CAP = 16'h0014;
  localparam logic [15:0] ETS_ADR_WAKE_CNT = 16'h0016;
  localparam logic [15:0] ETS_ADR_ADV = 16'h003C;
  localparam logic [15:0] ETS_ADR_LP_ADV = 16'h003D;
  localparam logic [15:0] ETS_ADR_TS_CAP = 16'h0708;
  localparam logic [15:0] ETS_ADR_TX_MAX = 16'h0709;
  localparam logic [15:0] ETS_ADR_TX_MIN = 16'h070B;
  localparam logic [15:0] ETS_ADR_RX_MAX = 16'h070D;
  localparam logic [15:0] ETS_ADR_RX_MIN = 16'h070F;

  // Bit positions
  localparam int ETS_BIT_RX_LINK = 2;
  localparam int ETS_BIT_TX_LPI_SEEN = 11;
  localparam int ETS_BIT_RX_LPI_SEEN = 10;
  localparam int ETS_BIT_TX_LPI_NOW = 9;
  localparam int ETS_BIT_RX_LPI_NOW = 8;
  localparam int ETS_BIT_EEE_1000 = 2;
  localparam int ETS_BIT_EEE_100 = 1;
  localparam int ETS_BIT_TS_RX = 1;
  localparam int ETS_BIT_TS_TX = 0;

  localparam logic [1:0] ETS_ADV_RESET = 2'h0;
  localparam logic [15:0] ETS_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] ETS_ZERO16 = 16'h0000;

  // One access to the basic register set
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] regad;
    logic [15:0] wdata;
  } ets_mgmt_req_s;

  // Live status from the PHY core
  typedef struct packed {
    logic link_up;
    logic pma_rx_link;
    logic pcs_rx_link;
    logic tx_lpi;
    logic rx_lpi;
    logic wake_fault;
    logic an_done;
    logic [1:0] lp_adv;
  } ets_phy_status_s;

endpackage : ets_pkg

// *** hw/ets_mmd_regs.sv ***
// Indirect management register set for energy-saving status and time-sync latency.
// Assumes an upstream serial management decoder presents one access per cycle on
// mgmt_req, and that PHY status inputs are synchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none

module ets_mmd_regs
  import ets_pkg::*;
#(
  parameter logic EEE_1000_CAPABLE = 1'b1,
  parameter logic EEE_100_CAPABLE = 1'b1,
  parameter logic [1:0] PMA_TS_CAPABLE = 2'h3,
  parameter logic [1:0] XS_TS_CAPABLE = 2'h3,
  parameter logic [15:0] PMA_TX_MAX = 16'h0000,
  parameter logic [15:0] PMA_TX_MIN = 16'h0000,
  parameter logic [15:0] PMA_RX_MAX = 16'h0000,
  parameter logic [15:0] PMA_RX_MIN = 16'h0000,
  parameter logic [15:0] XS_TX_MAX = 16'h0000,
  parameter logic [15:0] XS_TX_MIN = 16'h0000,
  parameter logic [15:0] XS_RX_MAX = 16'h0000,
  parameter logic [15:0] XS_RX_MIN = 16'h0000
) (
  input wire logic clk_sys, // 50 MHz management clock
  input wire logic reset, // Hardware reset, sync, active high
  input wire logic soft_reset, // Software reset pulse, sync, active high
  input wire ets_mgmt_req_s mgmt_req, // Access to basic registers
  input wire ets_phy_status_s phy_status, // Live PHY core status
  output logic [15:0] rdata, // Read data of last read
  output logic rdata_valid, // One-cycle pulse with rdata
  output logic [1:0] next_page_adv // Advertisement for the next page
);

  typedef struct packed {
    logic [1:0] func;
    logic [4:0] devad;
    logic [15:0] addr;
    logic pma_link_ll;
    logic pcs_link_ll;
    logic tx_lpi_lh;
    logic rx_lpi_lh;
    logic [15:0] wake_cnt;
    logic [1:0] adv;
    logic [1:0] lp_adv;
    logic [15:0] rdata;
    logic rvalid;
  } ets_state_s;

  ets_state_s st;
  ets_state_s next_st;

  logic acc_data;
  logic rd_hit;
  logic wr_hit;
  logic [15:0] mmd_rd;
  logic ts_zero;

  // One word per register keeps the device mux a plain selector
  logic [15:0] pma_status_word;
  logic [15:0] pma_ts_cap_word;
  logic [15:0] pma_tx_max_word;
  logic [15:0] pma_tx_min_word;
  logic [15:0] pma_rx_max_word;
  logic [15:0] pma_rx_min_word;
  logic [15:0] pcs_status_word;
  logic [15:0] eee_cap_word;
  logic [15:0] wake_cnt_word;
  logic [15:0] xs_ts_cap_word;
  logic [15:0] xs_tx_max_word;
  logic [15:0] xs_tx_min_word;
  logic [15:0] xs_rx_max_word;
  logic [15:0] xs_rx_min_word;
  logic [15:0] adv_word;
  logic [15:0] lp_adv_word;
  logic [15:0] pma_rd;
  logic [15:0] pcs_rd;
  logic [15:0] xs_rd;
  logic [15:0] an_rd;

  always_comb begin
    // Data function on register 14 reaches the extended space
    acc_data = (mgmt_req.regad == ETS_REG_MMD_DATA) && (st.func != ETS_FUNC_ADDR);
    rd_hit = acc_data && mgmt_req.rd;
    wr_hit = acc_data && mgmt_req.wr;
    // Gating follows the live level, so a read in the drop cycle already returns zero
    ts_zero = !phy_status.link_up;
  end

  // Reserved bits of every status word read zero
  always_comb begin
    pma_status_word = ETS_ZERO16;
    pma_status_word[ETS_BIT_RX_LINK] = st.pma_link_ll;
    pcs_status_word = ETS_ZERO16;
    pcs_status_word[ETS_BIT_TX_LPI_SEEN] = st.tx_lpi_lh;
    pcs_status_word[ETS_BIT_RX_LPI_SEEN] = st.rx_lpi_lh;
    pcs_status_word[ETS_BIT_TX_LPI_NOW] = phy_status.tx_lpi;
    pcs_status_word[ETS_BIT_RX_LPI_NOW] = phy_status.rx_lpi;
    pcs_status_word[ETS_BIT_RX_LINK] = st.pcs_link_ll;
    eee_cap_word = ETS_ZERO16;
    eee_cap_word[ETS_BIT_EEE_1000] = EEE_1000_CAPABLE;
    eee_cap_word[ETS_BIT_EEE_100] = EEE_100_CAPABLE;
    wake_cnt_word = st.wake_cnt;
  end

  // Gating at the word keeps every later path from leaking latency values
  always_comb begin
    pma_ts_cap_word = ETS_ZERO16;
    pma_tx_max_word = ETS_ZERO16;
    pma_tx_min_word = ETS_ZERO16;
    pma_rx_max_word = ETS_ZERO16;
    pma_rx_min_word = ETS_ZERO16;

    if (!ts_zero) begin
      pma_ts_cap_word[ETS_BIT_TS_RX] = PMA_TS_CAPABLE[ETS_BIT_TS_RX];
      pma_ts_cap_word[ETS_BIT_TS_TX] = PMA_TS_CAPABLE[ETS_BIT_TS_TX];
      pma_tx_max_word = PMA_TX_MAX;
      pma_tx_min_word = PMA_TX_MIN;
      pma_rx_max_word = PMA_RX_MAX;
      pma_rx_min_word = PMA_RX_MIN;
    end
  end

  always_comb begin
    xs_ts_cap_word = ETS_ZERO16;
    xs_tx_max_word = ETS_ZERO16;
    xs_tx_min_word = ETS_ZERO16;
    xs_rx_max_word = ETS_ZERO16;
    xs_rx_min_word = ETS_ZERO16;

    if (!ts_zero) begin
      xs_ts_cap_word[ETS_BIT_TS_RX] = XS_TS_CAPABLE[ETS_BIT_TS_RX];
      xs_ts_cap_word[ETS_BIT_TS_TX] = XS_TS_CAPABLE[ETS_BIT_TS_TX];
      xs_tx_max_word = XS_TX_MAX;
      xs_tx_min_word = XS_TX_MIN;
      xs_rx_max_word = XS_RX_MAX;
      xs_rx_min_word = XS_RX_MIN;
    end
  end

  always_comb begin
    adv_word = ETS_ZERO16;
    adv_word[ETS_BIT_EEE_1000] = st.adv[1];
    adv_word[ETS_BIT_EEE_100] = st.adv[0];
    lp_adv_word = ETS_ZERO16;
    lp_adv_word[ETS_BIT_EEE_1000] = st.lp_adv[1];
    lp_adv_word[ETS_BIT_EEE_100] = st.lp_adv[0];
  end

  // Per-device selectors; unknown register numbers read zero
  always_comb begin
    pma_rd = ETS_ZERO16;
    case (st.addr)
      ETS_ADR_STATUS1: pma_rd = pma_status_word;
      ETS_ADR_TS_CAP: pma_rd = pma_ts_cap_word;
      ETS_ADR_TX_MAX: pma_rd = pma_tx_max_word;
      ETS_ADR_TX_MIN: pma_rd = pma_tx_min_word;
      ETS_ADR_RX_MAX: pma_rd = pma_rx_max_word;
      ETS_ADR_RX_MIN: pma_rd = pma_rx_min_word;
      default: pma_rd = ETS_ZERO16;
    endcase
  end

  always_comb begin
    pcs_rd = ETS_ZERO16;
    case (st.addr)
      ETS_ADR_STATUS1: pcs_rd = pcs_status_word;
      ETS_ADR_CAP: pcs_rd = eee_cap_word;
      ETS_ADR_WAKE_CNT: pcs_rd = wake_cnt_word;
      default: pcs_rd = ETS_ZERO16;
    endcase
  end

  always_comb begin
    xs_rd = ETS_ZERO16;
    case (st.addr)
      ETS_ADR_TS_CAP: xs_rd = xs_ts_cap_word;
      ETS_ADR_TX_MAX: xs_rd = xs_tx_max_word;
      ETS_ADR_TX_MIN: xs_rd = xs_tx_min_word;
      ETS_ADR_RX_MAX: xs_rd = xs_rx_max_word;
      ETS_ADR_RX_MIN: xs_rd = xs_rx_min_word;
      default: xs_rd = ETS_ZERO16;
    endcase
  end

  always_comb begin
    an_rd = ETS_ZERO16;
    case (st.addr)
      ETS_ADR_ADV: an_rd = adv_word;
      ETS_ADR_LP_ADV: an_rd = lp_adv_word;
      default: an_rd = ETS_ZERO16;
    endcase
  end

  // Only the device selected in register 13 answers
  always_comb begin
    mmd_rd = ETS_ZERO16;
    case (st.devad)
      ETS_DEV_PMA: mmd_rd = pma_rd;
      ETS_DEV_PCS: mmd_rd = pcs_rd;
      ETS_DEV_XS: mmd_rd = xs_rd;
      ETS_DEV_AN: mmd_rd = an_rd;
      default: mmd_rd = ETS_ZERO16;
    endcase
  end

  logic rd_pma_st;
  logic rd_pcs_st;
  logic rd_cnt;
  logic ctrl_wr;
  logic addr_wr;
  logic adv_wr;
  logic inc_step;
  logic [15:0] ctrl_word;
  logic [15:0] bus_rd_word;
  logic [15:0] next_addr;
  logic [1:0] next_adv;
  logic [1:0] next_lp_adv;
  logic next_pma_ll;
  logic next_pcs_ll;
  logic next_tx_lh;
  logic next_rx_lh;
  logic [15:0] next_wake_cnt;

  // Side effects decode the register addressed before this cycle's writes
  always_comb begin
    rd_pma_st = rd_hit && (st.devad == ETS_DEV_PMA) && (st.addr == ETS_ADR_STATUS1);
    rd_pcs_st = rd_hit && (st.devad == ETS_DEV_PCS) && (st.addr == ETS_ADR_STATUS1);
    rd_cnt = rd_hit && (st.devad == ETS_DEV_PCS) && (st.addr == ETS_ADR_WAKE_CNT);
    ctrl_wr = mgmt_req.wr && (mgmt_req.regad == ETS_REG_MMD_CTRL);
    addr_wr = mgmt_req.wr && (mgmt_req.regad == ETS_REG_MMD_DATA) &&
              (st.func == ETS_FUNC_ADDR);
    adv_wr = wr_hit && (st.devad == ETS_DEV_AN) && (st.addr == ETS_ADR_ADV);
    // Post-increment functions step the address after each data write; only ETS_FUNC_DATA_INC_RW also steps after reads
    inc_step = (rd_hit && st.func == ETS_FUNC_DATA_INC_RW) ||
               (wr_hit && (st.func == ETS_FUNC_DATA_INC_RW || st.func == ETS_FUNC_DATA_INC_WR));
  end

  // Register 13 reads back function and device; the middle bits read zero
  always_comb begin
    ctrl_word = ETS_ZERO16;
    ctrl_word[ETS_CTRL_FUNC_HI:ETS_CTRL_FUNC_LO] = st.func;
    ctrl_word[ETS_CTRL_DEV_HI:0] = st.devad;
  end

  // Register 14 returns the shared address while the address function is selected
  always_comb begin
    bus_rd_word = ETS_ZERO16;
    case (mgmt_req.regad)
      ETS_REG_MMD_CTRL: bus_rd_word = ctrl_word;
      ETS_REG_MMD_DATA: bus_rd_word = acc_data ? mmd_rd : st.addr;
      default: bus_rd_word = ETS_ZERO16;
    endcase
  end

  // One address register serves every device; the increment wraps at the top
  always_comb begin
    next_addr = st.addr;
    if (addr_wr) begin
      next_addr = mgmt_req.wdata;
    end
    if (inc_step) begin
      next_addr = st.addr + 16'h0001;
    end
  end

  // Only the advertisement bits take writes; partner register ignores them
  always_comb begin
    next_adv = st.adv;
    if (adv_wr) begin
      next_adv[1] = mgmt_req.wdata[ETS_BIT_EEE_1000];
      next_adv[0] = mgmt_req.wdata[ETS_BIT_EEE_100];
    end
  end

  always_comb begin
    next_lp_adv = st.lp_adv;
    if (phy_status.an_done) begin
      next_lp_adv = phy_status.lp_adv;
    end
  end

  // Latch-low: a read rearms to the live level, so a drop in the read cycle is kept
  always_comb begin
    next_pma_ll = phy_status.pma_rx_link &
                  (rd_pma_st | st.pma_link_ll);
    next_pcs_ll = phy_status.pcs_rx_link &
                  (rd_pcs_st | st.pcs_link_ll);
    // Latch-high: a new event wins over the clear from a read
    next_tx_lh = phy_status.tx_lpi | (st.tx_lpi_lh & !rd_pcs_st);
    next_rx_lh = phy_status.rx_lpi | (st.rx_lpi_lh & !rd_pcs_st);
  end

  // A fault in the reading cycle restarts the count at one rather than being lost
  always_comb begin
    next_wake_cnt = st.wake_cnt;
    if (rd_cnt) begin
      next_wake_cnt = phy_status.wake_fault ? 16'h0001 : ETS_ZERO16;
    end else if (phy_status.wake_fault && st.wake_cnt != ETS_CNT_MAX) begin
      next_wake_cnt = st.wake_cnt + 16'h0001;
    end
  end

  always_comb begin
    next_st = st;
    next_st.rvalid = mgmt_req.rd;

    // Read data holds between reads and shows state before this cycle's side effects
    if (mgmt_req.rd) begin
      next_st.rdata = bus_rd_word;
    end

    // Access-control writes
    if (ctrl_wr) begin
      next_st.func = mgmt_req.wdata[ETS_CTRL_FUNC_HI:ETS_CTRL_FUNC_LO];
      next_st.devad = mgmt_req.wdata[ETS_CTRL_DEV_HI:0];
    end

    next_st.addr = next_addr;
    next_st.adv = next_adv;
    next_st.lp_adv = next_lp_adv;
    next_st.pma_link_ll = next_pma_ll;
    next_st.pcs_link_ll = next_pcs_ll;
    next_st.tx_lpi_lh = next_tx_lh;
    next_st.rx_lpi_lh = next_rx_lh;
    next_st.wake_cnt = next_wake_cnt;
  end

  always_ff @(posedge clk_sys) begin
    if (reset || soft_reset) begin
      // Both resets clear alike; latch-low bits restart high so no false drop is seen
      st.func <= ETS_FUNC_ADDR;
      st.devad <= 5'h00;
      st.addr <= ETS_ZERO16;
      st.pma_link_ll <= 1'b1;
      st.pcs_link_ll <= 1'b1;
      st.tx_lpi_lh <= 1'b0;
      st.rx_lpi_lh <= 1'b0;
      st.wake_cnt <= ETS_ZERO16;
      st.adv <= ETS_ADV_RESET;
      st.lp_adv <= 2'h0;
      st.rdata <= ETS_ZERO16;
      st.rvalid <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign rdata_valid = st.rvalid;
  assign next_page_adv = st.adv;

endmodule : ets_mmd_regs

`default_nettype wire

// *** tb/ets_mmd_regs_chk.sv ***
// Port assertions for the indirect register set.
// Assumes it is bound to ets_mmd_regs; both resets are synchronous.
`timescale 1ns/1ns
`default_nettype none
module ets_mmd_regs_chk
  import ets_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic reset, // Hardware reset
  input wire logic soft_reset, // Software reset
  input wire ets_mgmt_req_s mgmt_req, // Register requests
  input wire ets_phy_status_s phy_status, // Core status
  input wire logic [15:0] rdata, // Read data
  input wire logic rdata_valid, // Read strobe
  input wire logic [1:0] next_page_adv // Advertisement
);
  logic any_rst;
  assign any_rst = reset || soft_reset;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (any_rst);
  property p_rd_answer; mgmt_req.rd |=> rdata_valid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_no_spurious; !mgmt_req.rd |=> !rdata_valid; endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("stray strobe");
  property p_unmapped; mgmt_req.rd && mgmt_req.regad != ETS_REG_MMD_CTRL
    && mgmt_req.regad != ETS_REG_MMD_DATA |=> rdata == ETS_ZERO16; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_holds; !rdata_valid && !$past(any_rst) |-> $stable(rdata); endproperty
  a_holds: assert property (p_holds) else $error("read data moved");
  property p_adv_reset; disable iff (1'b0) reset |=> next_page_adv == ETS_ADV_RESET; endproperty
  a_adv_reset: assert property (p_adv_reset) else $error("advert reset");
  property p_soft; disable iff (1'b0) soft_reset && !reset |=>
    rdata == ETS_ZERO16 && !rdata_valid && next_page_adv == ETS_ADV_RESET; endproperty
  a_soft: assert property (p_soft) else $error("soft reset");
  property p_adv_wr; $changed(next_page_adv) |-> $past(mgmt_req.wr) || $past(any_rst); endproperty
  a_adv_wr: assert property (p_adv_wr) else $error("advert moved alone");
  property p_wr_silent; mgmt_req.wr |=> !rdata_valid; endproperty
  a_wr_silent: assert property (p_wr_silent) else $error("write answered");
endmodule : ets_mmd_regs_chk
bind ets_mmd_regs ets_mmd_regs_chk ets_mmd_regs_chk_inst (.clk_sys(clk_sys), .reset(reset),
  .soft_reset(soft_reset), .mgmt_req(mgmt_req), .phy_status(phy_status), .rdata(rdata),
  .rdata_valid(rdata_valid), .next_page_adv(next_page_adv));
`default_nettype wire

// *** tb/ets_host_model.sv ***
// Station manager model on the basic register port.
// Assumes the bench calls its tasks; requests change at the falling edge.
`timescale 1ns/1ns
`default_nettype none
module ets_host_model
  import ets_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic [15:0] rdata, // Read data
  input wire logic rdata_valid, // Read strobe
  output var ets_mgmt_req_s mgmt_req // Requests
);
  initial mgmt_req = '0;
  task automatic breg(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] d, output logic ok);
    ok = !rd;
    d = 16'h0000;
    @(negedge clk_sys);
    mgmt_req = '{rd: rd, wr: !rd, regad: ra, wdata: wd};
    @(negedge clk_sys);
    // Released lines flip so a stale value never passes for a current one
    mgmt_req = '{rd: 1'b0, wr: 1'b0, regad: ~ra, wdata: ~wd};
    for (int i = 0; i < 4 && !ok; i++) begin
      if (rdata_valid === 1'b1) begin
        ok = 1'b1;
        d = rdata;
      end else @(negedge clk_sys);
    end
  endtask : breg
  task automatic mmd(input logic rd, input logic [4:0] dev, input logic [15:0] adr,
                     input logic [15:0] wd, output logic [15:0] d, output logic ok);
    breg(1'b0, ETS_REG_MMD_CTRL, {ETS_FUNC_ADDR, 9'h000, dev}, d, ok);
    breg(1'b0, ETS_REG_MMD_DATA, adr, d, ok);
    breg(1'b0, ETS_REG_MMD_CTRL, {ETS_FUNC_DATA, 9'h000, dev}, d, ok);
    breg(rd, ETS_REG_MMD_DATA, wd, d, ok);
  endtask : mmd
endmodule : ets_host_model
`default_nettype wire

// *** tb/ets_mmd_regs_tb.sv ***
// Self-checking bench for the indirect register set.
// Assumes ets_host_model issues every register access.
`timescale 1ns/1ns
`default_nettype none
module ets_mmd_regs_tb;
  import ets_pkg::*;
  logic clk_sys;
  logic reset;
  logic soft_reset;
  ets_mgmt_req_s mgmt_req;
  ets_phy_status_s phy_status;
  logic [15:0] rdata;
  logic rdata_valid;
  logic [1:0] next_page_adv;
  int n_mismatch = 0;
  int comparisons = 0;
  ets_mmd_regs #(.PMA_TS_CAPABLE(2'h1), .PMA_TX_MAX(16'h1109), .PMA_RX_MAX(16'h110D),
    .XS_TX_MIN(16'h440B), .XS_RX_MIN(16'h440F)) ets_mmd_regs_inst (
    .clk_sys(clk_sys), .reset(reset), .soft_reset(soft_reset), .mgmt_req(mgmt_req),
    .phy_status(phy_status), .rdata(rdata), .rdata_valid(rdata_valid),
    .next_page_adv(next_page_adv));
  ets_host_model ets_host_model_inst (.clk_sys(clk_sys), .rdata(rdata),
    .rdata_valid(rdata_valid), .mgmt_req(mgmt_req));
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic rc(input logic [4:0] dev, input logic [15:0] adr, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    ets_host_model_inst.mmd(1'b1, dev, adr, 16'h0000, d, ok);
    if (!ok) begin
      n_mismatch++;
      report_and_stop();
    end
    check(d, exp);
  endtask : rc
  task automatic wr(input logic [4:0] dev, input logic [15:0] adr, input logic [15:0] v);
    logic [15:0] d;
    logic ok;
    ets_host_model_inst.mmd(1'b0, dev, adr, v, d, ok);
  endtask : wr
  task automatic t_advert;
    logic [15:0] d;
    logic ok;
    ets_host_model_inst.breg(1'b1, 5'h00, 16'h0000, d, ok);
    check(d, 16'h0000);
    rc(ETS_DEV_PCS, ETS_ADR_CAP, 16'h0006);
    rc(ETS_DEV_AN, ETS_ADR_ADV, 16'h0000);
    wr(ETS_DEV_AN, ETS_ADR_ADV, 16'hFFFF);
    rc(ETS_DEV_AN, ETS_ADR_ADV, 16'h0006);
    check({14'h0, next_page_adv}, 16'h0003);
    wr(ETS_DEV_AN, ETS_ADR_ADV, 16'h0002);
    wr(ETS_DEV_AN, ETS_ADR_LP_ADV, 16'hFFFF);
    rc(ETS_DEV_AN, ETS_ADR_LP_ADV, 16'h0000);
    check({14'h0, next_page_adv}, 16'h0001);
    @(negedge clk_sys);
    phy_status.lp_adv = 2'h2;
    phy_status.an_done = 1'b1;
    @(negedge clk_sys);
    phy_status.lp_adv = 2'h1;
    phy_status.an_done = 1'b0;
    rc(ETS_DEV_AN, ETS_ADR_LP_ADV, 16'h0004);
    $display("t_advert done");
  endtask : t_advert
  task automatic t_lpi;
    rc(ETS_DEV_PCS, ETS_ADR_STATUS1, 16'h0004);
    @(negedge clk_sys);
    phy_status = '{link_up: 1'b1, tx_lpi: 1'b1, default: '0};
    @(negedge clk_sys);
    phy_status = '{link_up: 1'b1, pma_rx_link: 1'b1, pcs_rx_link: 1'b1, default: '0};
    rc(ETS_DEV_PCS, ETS_ADR_STATUS1, 16'h0800);
    rc(ETS_DEV_PCS, ETS_ADR_STATUS1, 16'h0004);
    rc(ETS_DEV_PMA, ETS_ADR_STATUS1, 16'h0000);
    rc(ETS_DEV_PMA, ETS_ADR_STATUS1, 16'h0004);
    phy_status.rx_lpi = 1'b1;
    rc(ETS_DEV_PCS, ETS_ADR_STATUS1, 16'h0504);
    phy_status.tx_lpi = 1'b1;
    rc(ETS_DEV_PCS, ETS_ADR_STATUS1, 16'h0F04);
    phy_status.rx_lpi = 1'b0;
    phy_status.tx_lpi = 1'b0;
    rc(ETS_DEV_PCS, ETS_ADR_STATUS1, 16'h0C04);
    rc(ETS_DEV_PCS, ETS_ADR_STATUS1, 16'h0004);
    $display("t_lpi done");
  endtask : t_lpi
  task automatic t_wake;
    rc(ETS_DEV_PCS, ETS_ADR_WAKE_CNT, 16'h0000);
    repeat (3) begin
      @(negedge clk_sys) phy_status.wake_fault = 1'b1;
      @(negedge clk_sys) phy_status.wake_fault = 1'b0;
    end
    rc(ETS_DEV_PCS, ETS_ADR_WAKE_CNT, 16'h0003);
    rc(ETS_DEV_PCS, ETS_ADR_WAKE_CNT, 16'h0000);
    // Held high the fault input counts once a cycle and saturates at the 16-bit top
    @(negedge clk_sys) phy_status.wake_fault = 1'b1;
    repeat (65540) @(negedge clk_sys);
    phy_status.wake_fault = 1'b0;
    rc(ETS_DEV_PCS, ETS_ADR_WAKE_CNT, 16'hFFFF);
    @(negedge clk_sys) soft_reset = 1'b1;
    @(negedge clk_sys) soft_reset = 1'b0;
    rc(ETS_DEV_PCS, ETS_ADR_WAKE_CNT, 16'h0000);
    rc(ETS_DEV_AN, ETS_ADR_ADV, 16'h0000);
    $display("t_wake done");
  endtask : t_wake
  task automatic t_latency;
    logic [15:0] adr[5] = '{ETS_ADR_TS_CAP, ETS_ADR_TX_MAX, ETS_ADR_TX_MIN, ETS_ADR_RX_MAX,
                            ETS_ADR_RX_MIN};
    // Defaulted latency values read zero, so a swapped max/min decode still shows
    logic [15:0] want[10] = '{16'h0001, 16'h1109, 16'h0000, 16'h110D, 16'h0000,
                              16'h0003, 16'h0000, 16'h440B, 16'h0000, 16'h440F};
    for (int l = 1; l >= 0; l--) begin
      phy_status.link_up = l[0];
      for (int i = 0; i < 10; i++) begin
        rc(i < 5 ? ETS_DEV_PMA : ETS_DEV_XS, adr[i % 5], l[0] ? want[i] : 16'h0000);
      end
    end
    $display("t_latency done");
  endtask : t_latency
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    reset = 1'b1;
    soft_reset = 1'b0;
    phy_status = '{link_up: 1'b1, pma_rx_link: 1'b1, pcs_rx_link: 1'b1, default: '0};
    repeat (6) @(negedge clk_sys);
    reset = 1'b0;
    t_advert();
    t_lpi();
    t_wake();
    t_latency();
    report_and_stop();
  end
endmodule : ets_mmd_regs_tb
`default_nettype wire
